// ===== hdl/dcdaw_alu.sv
// Combinational arithmetic for decrement and decimal adjust
module dcdaw_alu (
  input  wire logic [7:0]             operand_in,
  input  wire logic [7:0]             working_register_alias_in,
  input  wire dcdaw_pkg::dcdaw_flags_s flags_in,
  output logic [7:0]                  decrement_file_op_res_out,
  output dcdaw_pkg::dcdaw_flags_s     decrement_file_op_flags_out,
  output logic [7:0]                  daw_res_out,
  output logic                        daw_c_out
);

  logic [8:0] lo_sum;
  logic [8:0] hi_sum;
  logic       hi_fix;

  // ----------------------------------------------------------------------
  // Decrement: a subtraction of one, carry means no borrow
  // ----------------------------------------------------------------------
  always_comb begin
    decrement_file_op_res_out                    = operand_in - 8'h01;
    decrement_file_op_flags_out.carry            = (operand_in != 8'h00);
    decrement_file_op_flags_out.digit_carry_flag = (operand_in[3:0] != 4'h0);
    decrement_file_op_flags_out.overflow_flag    = (operand_in == 8'h80);
    decrement_file_op_flags_out.negative         = decrement_file_op_res_out[7];
    decrement_file_op_flags_out.zero             = (decrement_file_op_res_out == 8'h00);
  end

  // ----------------------------------------------------------------------
  // Decimal adjust: low digit first so its carry feeds the high test
  // ----------------------------------------------------------------------
  always_comb begin
    lo_sum = {1'b0, working_register_alias_in};
    if ((working_register_alias_in[3:0] > 4'h9) || flags_in.digit_carry_flag) begin
      lo_sum = {1'b0, working_register_alias_in} + 9'h006;
    end
    hi_fix = (lo_sum[7:4] > 4'h9) || lo_sum[8] || flags_in.carry;
    hi_sum = hi_fix ? (lo_sum + 9'h060) : lo_sum;
    daw_res_out = hi_sum[7:0];
    daw_c_out   = hi_fix ? 1'b1 : flags_in.carry;
  end

endmodule // dcdaw_alu

// ===== hdl/dcdaw_exec.sv
// Decrement-file and decimal-adjust execution datapath with an AHB-Lite register slave
//
// Local design decisions: register access over AHB-Lite and the address map.
module dcdaw_exec (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out
);

  localparam int AW = dcdaw_pkg::DATA_ADDR_W;

  dcdaw_pkg::dcdaw_state_s q;
  dcdaw_pkg::dcdaw_state_s d;

  logic [7:0]              mem [2**AW];
  logic                    mem_we;
  logic [AW-1:0]           mem_wa;
  logic [7:0]              mem_wd;

  logic                    bus_take;
  logic                    wr_phase;
  logic                    exec_decrement_file_op;
  logic                    exec_daw;
  logic                    cmd_d;
  logic                    cmd_a;
  logic [7:0]              cmd_f;
  logic [AW-1:0]           exec_addr;
  logic [7:0]              operand;
  logic [7:0]              decrement_file_op_res;
  dcdaw_pkg::dcdaw_flags_s decrement_file_op_flags;
  logic [7:0]              daw_res;
  logic                    daw_c;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [AW-1:0] operand_addr(
    input logic                          a,
    input logic [7:0]                    f,
    input logic [dcdaw_pkg::BANK_W-1:0]  bank,
    input logic                          ext,
    input logic [AW-1:0]                 base
  );
    logic [AW-1:0] r;
    if (!a && ext && (f <= dcdaw_pkg::ILO_MAX)) begin
      r = base + {4'h0, f};
    end else if (a) begin
      r = {bank, f};
    end else if (f < dcdaw_pkg::ACCESS_SPLIT) begin
      r = {dcdaw_pkg::ACCESS_LOW, f};
    end else begin
      r = {dcdaw_pkg::ACCESS_HIGH, f};
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_read(
    input logic [7:0]              off,
    input dcdaw_pkg::dcdaw_state_s s,
    input logic [7:0]              mdata
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (off)
      dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS:   r = {24'h00_0000, s.working_register_alias};
      dcdaw_pkg::OFF_STATUS: r = {27'h000_0000, s.flags};
      dcdaw_pkg::OFF_BANK:   r = {28'h000_0000, s.bank_select_register};
      dcdaw_pkg::OFF_CFG:    r = {31'h0000_0000, s.ext_en};
      dcdaw_pkg::OFF_IDX:    r = {20'h0_0000, s.idx_base};
      dcdaw_pkg::OFF_MADDR:  r = {20'h0_0000, s.mem_addr};
      dcdaw_pkg::OFF_MDATA:  r = {24'h00_0000, mdata};
      default:               r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Command decode: an instruction runs in the data phase of its CMD write
  // ----------------------------------------------------------------------
  assign bus_take  = hsel_in && hready_in && htrans_in[1];
  assign wr_phase  = q.pend_valid && q.pend_write;
  assign cmd_d     = hwdata_in[dcdaw_pkg::CMD_D_BIT];
  assign cmd_a     = hwdata_in[dcdaw_pkg::CMD_A_BIT];
  assign cmd_f     = hwdata_in[dcdaw_pkg::CMD_F_LSB +: 8];
  assign exec_decrement_file_op = wr_phase && (q.pend_off == dcdaw_pkg::OFF_CMD) &&
                     (hwdata_in[dcdaw_pkg::CMD_OP_LSB +: 2] == dcdaw_pkg::DCDAW_OP_DECREMENT_FILE);
  assign exec_daw  = wr_phase && (q.pend_off == dcdaw_pkg::OFF_CMD) &&
                     (hwdata_in[dcdaw_pkg::CMD_OP_LSB +: 2] == dcdaw_pkg::DCDAW_OP_DECIMAL_ADJUST);
  assign exec_addr = operand_addr(cmd_a, cmd_f, q.bank_select_register, q.ext_en, q.idx_base);
  assign operand   = mem[exec_addr];

  dcdaw_alu u_alu (
    .operand_in     (operand),
    .working_register_alias_in        (q.working_register_alias),
    .flags_in       (q.flags),
    .decrement_file_op_res_out   (decrement_file_op_res),
    .decrement_file_op_flags_out (decrement_file_op_flags),
    .daw_res_out    (daw_res),
    .daw_c_out      (daw_c)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d      = q;
    mem_we = 1'b0;
    mem_wa = q.mem_addr;
    mem_wd = hwdata_in[7:0];
    // Reads wait one cycle so a write still in its data phase lands first
    if (q.rd_wait) begin
      d.hrdata     = reg_read(q.pend_off, q, mem[q.mem_addr]);
      d.hready     = 1'b1;
      d.rd_wait    = 1'b0;
      d.pend_valid = 1'b0;
    end else if (wr_phase) begin
      d.pend_valid = 1'b0;
      case (q.pend_off)
        dcdaw_pkg::OFF_CMD: begin
          if (exec_decrement_file_op) begin
            d.flags = decrement_file_op_flags;
            if (cmd_d) begin
              mem_we = 1'b1;
              mem_wa = exec_addr;
              mem_wd = decrement_file_op_res;
            end else begin
              d.working_register_alias = decrement_file_op_res;
            end
          end else if (exec_daw) begin
            d.working_register_alias = daw_res;
            d.flags.carry            = daw_c;
          end
        end
        dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS:   d.working_register_alias = hwdata_in[7:0];
        dcdaw_pkg::OFF_STATUS: d.flags = hwdata_in[4:0];
        dcdaw_pkg::OFF_BANK:   d.bank_select_register = hwdata_in[dcdaw_pkg::BANK_W-1:0];
        dcdaw_pkg::OFF_CFG:    d.ext_en = hwdata_in[dcdaw_pkg::CFG_EXT_BIT];
        dcdaw_pkg::OFF_IDX:    d.idx_base = hwdata_in[AW-1:0];
        dcdaw_pkg::OFF_MADDR:  d.mem_addr = hwdata_in[AW-1:0];
        dcdaw_pkg::OFF_MDATA:  mem_we = 1'b1;
        default:               d.pend_valid = 1'b0;
      endcase
    end
    if (bus_take) begin
      d.pend_valid = 1'b1;
      d.pend_write = hwrite_in;
      d.pend_off   = {haddr_in[7:2], 2'b00};
      if (!hwrite_in) begin
        d.rd_wait = 1'b1;
        d.hready  = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // State and memory
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q                        <= '0;
      q.working_register_alias <= dcdaw_pkg::RST_WORKING_REGISTER_ALIAS;
      q.bank_select_register   <= dcdaw_pkg::RST_BANK;
      q.idx_base               <= dcdaw_pkg::RST_ADDR;
      q.mem_addr               <= dcdaw_pkg::RST_ADDR;
      q.hready                 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Data memory has no reset: software must load bytes before use
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_comb begin
    hreadyout_out = q.hready;
    hrdata_out    = q.hrdata;
    hresp_out     = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_daw_ce;
    exec_daw && (q.working_register_alias == 8'hCE) && !q.flags.carry &&
    !q.flags.digit_carry_flag;
  endsequence

  sequence s_daw_34;
    (q.working_register_alias == 8'h34) && q.flags.carry && !q.flags.digit_carry_flag;
  endsequence

  AST_DECREMENT_FILE_OP_TO_W: assert property (
    exec_decrement_file_op && !cmd_d |=> q.working_register_alias == ($past(operand) - 8'h01))
    else $error("Decrement to W gave wrong value");

  AST_DECREMENT_FILE_OP_TO_MEM: assert property (
    exec_decrement_file_op && cmd_d |=> (mem[$past(exec_addr)] == ($past(operand) - 8'h01)) &&
      $stable(q.working_register_alias))
    else $error("Decrement to memory gave wrong value or touched W");

  AST_ACCESS_BANK: assert property (
    exec_decrement_file_op && !cmd_a && !(q.ext_en && cmd_f <= 8'h5F) |->
      exec_addr == ((cmd_f < 8'h60) ? {4'h0, cmd_f} : {4'hF, cmd_f}))
    else $error("Access bank address wrong");

  AST_BANKED: assert property (
    exec_decrement_file_op && cmd_a |-> exec_addr == {q.bank_select_register, cmd_f})
    else $error("Banked address wrong");

  AST_INDEXED: assert property (
    exec_decrement_file_op && !cmd_a && q.ext_en && cmd_f <= 8'h5F |->
      exec_addr == q.idx_base + {4'h0, cmd_f})
    else $error("Indexed literal offset address wrong");

  AST_DAW_CE: assert property (
    s_daw_ce |=> s_daw_34)
    else $error("Decimal adjust of CEh wrong");

  AST_DAW_BCD: assert property (
    exec_daw && (!q.flags.digit_carry_flag || q.working_register_alias[3:0] <= 4'h2) &&
      (!q.flags.carry || q.working_register_alias[7:4] <= 4'h2) |=>
      (q.working_register_alias[3:0] <= 4'h9) && (q.working_register_alias[7:4] <= 4'h9))
    else $error("Decimal adjust left a non-BCD digit");

  AST_DECREMENT_FILE_OP_ZERO: assert property (
    exec_decrement_file_op && operand == 8'h01 |=> q.flags.zero && !q.flags.negative && q.flags.carry)
    else $error("Decrement of 01h flags wrong");

  AST_DECREMENT_FILE_OP_FLAGS: assert property (
    exec_decrement_file_op |=> (q.flags.carry == ($past(operand) != 8'h00)) &&
      (q.flags.overflow_flag == ($past(operand) == 8'h80)) &&
      (q.flags.digit_carry_flag == ($past(operand[3:0]) != 4'h0)))
    else $error("Decrement flags wrong");

  AST_READ_WAIT: assert property (
    bus_take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("Read wait state wrong");

  // ----------------------------------------------------------------------
  // Further bus and datapath checks
  // ----------------------------------------------------------------------
  sequence s_write_taken;
    bus_take && hwrite_in;
  endsequence

  sequence s_cmd_idle;
    wr_phase && (q.pend_off == dcdaw_pkg::OFF_CMD) && !exec_decrement_file_op && !exec_daw;
  endsequence

  AST_RESP_OKAY: assert property (
    hresp_out == 1'b0)
    else $error("Bus response not OKAY");

  AST_WRITE_NO_WAIT: assert property (
    s_write_taken |=> hreadyout_out)
    else $error("Write data phase was stretched");

  // Read data must stand until the next read completes
  AST_HRDATA_HOLD: assert property (
    !q.rd_wait |=> $stable(hrdata_out))
    else $error("Read data changed outside a read");

  AST_DAW_DC_KEEP: assert property (
    exec_daw |=> $stable(q.flags.digit_carry_flag))
    else $error("Decimal adjust touched digit carry");

  AST_DAW_BCD_KEEP: assert property (
    exec_daw && (q.working_register_alias[3:0] <= 4'h9) &&
      (q.working_register_alias[7:4] <= 4'h9) && !q.flags.carry &&
      !q.flags.digit_carry_flag |=> $stable(q.working_register_alias))
    else $error("Decimal adjust changed a valid BCD value");

  AST_DECREMENT_FILE_OP_NEG: assert property (
    exec_decrement_file_op |=> q.flags.negative == (($past(operand) == 8'h00) || ($past(operand) > 8'h80)))
    else $error("Decrement negative flag wrong");

  AST_DECREMENT_FILE_OP_WB: assert property (
    exec_decrement_file_op && cmd_d |-> mem_we && (mem_wa == exec_addr))
    else $error("Decrement write back not issued");

  AST_CMD_IDLE: assert property (
    s_cmd_idle |=> $stable(q.working_register_alias) && $stable(q.flags))
    else $error("Unused command code changed state");

endmodule // dcdaw_exec

// ===== hdl/dcdaw_pkg.sv
// Shared constants and carrier types for the decrement and decimal adjust datapath
package dcdaw_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_WORKING_REGISTER_ALIAS   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK   = 8'h0C;
  localparam logic [7:0] OFF_CFG    = 8'h10;
  localparam logic [7:0] OFF_IDX    = 8'h14;
  localparam logic [7:0] OFF_MADDR  = 8'h18;
  localparam logic [7:0] OFF_MDATA  = 8'h1C;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_D_BIT   = 2;
  localparam int CMD_A_BIT   = 3;
  localparam int CMD_F_LSB   = 8;
  localparam int CFG_EXT_BIT = 0;

  // ----------------------------------------------------------------------
  // Address space and addressing limits
  // ----------------------------------------------------------------------
  localparam int         DATA_ADDR_W  = 12;
  localparam int         BANK_W       = DATA_ADDR_W - 8;
  localparam logic [7:0] ILO_MAX      = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH  = 4'hF;
  localparam logic [3:0] ACCESS_LOW   = 4'h0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]             RST_WORKING_REGISTER_ALIAS = 8'h00;
  localparam logic [BANK_W-1:0]      RST_BANK = 4'h0;
  localparam logic [DATA_ADDR_W-1:0] RST_ADDR = 12'h000;

  // ----------------------------------------------------------------------
  // Operations and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCDAW_OP_NONE           = 2'b00,
    DCDAW_OP_DECREMENT_FILE = 2'b01,
    DCDAW_OP_DECIMAL_ADJUST = 2'b10
  } dcdaw_op_e;

  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } dcdaw_flags_s;

  typedef struct packed {
    logic [7:0]             working_register_alias;
    dcdaw_flags_s           flags;
    logic [BANK_W-1:0]      bank_select_register;
    logic                   ext_en;
    logic [DATA_ADDR_W-1:0] idx_base;
    logic [DATA_ADDR_W-1:0] mem_addr;
    logic                   pend_valid;
    logic                   pend_write;
    logic [7:0]             pend_off;
    logic                   rd_wait;
    logic                   hready;
    logic [31:0]            hrdata;
  } dcdaw_state_s;

endpackage

// ===== sim/dcdaw_exec_tb.sv
// Self-checking testbench for the decrement and decimal adjust datapath
module dcdaw_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------------
  logic        clk_in;
  logic        rst_b_in;
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [2:0]  hsize_in;
  logic [31:0] hwdata_in;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [31:0] hrdata_out;
  int          n_mismatch;
  int          checks_done;

  dcdaw_exec dut (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hreadyout_out),
    .hreadyout_out (hreadyout_out),
    .hresp_out     (hresp_out),
    .hrdata_out    (hrdata_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ----------------------------------------------------------------------
  // Bus master and comparison
  // ----------------------------------------------------------------------
  // One single transfer; waits on hready in both phases, no fixed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_in   <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in  <= {24'h000000, a};
    hwrite_in <= wr;
    hsize_in  <= 3'b010;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'b00;
    hwdata_in <= wr ? wd : 32'h00000000;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rd = hrdata_out;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, a, 32'h00000000, got);
    check(got, exp);
    check({31'h00000000, hresp_out}, 32'h00000000);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic reset_values();
    for (int i = 1; i < 7; i++) begin
      rd_chk(8'(i * 4), 32'h00000000);
    end
    // Unmapped place: write ignored, read gives zero
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00000000);
    rd_chk(dcdaw_pkg::OFF_CMD, 32'h00000000);
  endtask

  // Seeds the operand, runs one decrement and checks W, flags and memory
  task automatic dec_case(input logic [3:0] bank, input logic ext, input logic [11:0] idx,
                          input logic a, input logic d, input logic [7:0] f,
                          input logic [11:0] addr, input logic [7:0] opnd,
                          input logic [7:0] res, input logic [4:0] stat);
    wr(dcdaw_pkg::OFF_BANK, {28'h0000000, bank});
    wr(dcdaw_pkg::OFF_CFG, {31'h00000000, ext});
    wr(dcdaw_pkg::OFF_IDX, {20'h00000, idx});
    wr(dcdaw_pkg::OFF_MADDR, {20'h00000, addr});
    wr(dcdaw_pkg::OFF_MDATA, {24'h000000, opnd});
    wr(dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS, 32'h0000005A);
    wr(dcdaw_pkg::OFF_STATUS, 32'h00000000);
    wr(dcdaw_pkg::OFF_CMD, {16'h0000, f, 4'h0, a, d, 2'b01});
    rd_chk(dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS, {24'h000000, (d ? 8'h5A : res)});
    rd_chk(dcdaw_pkg::OFF_STATUS, {27'h0000000, stat});
    rd_chk(dcdaw_pkg::OFF_MDATA, {24'h000000, (d ? res : opnd)});
  endtask

  task automatic adjust_case(input logic [7:0] w, input logic [4:0] st,
                             input logic [7:0] exp_w, input logic [4:0] exp_st);
    wr(dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS, {24'h000000, w});
    wr(dcdaw_pkg::OFF_STATUS, {27'h0000000, st});
    wr(dcdaw_pkg::OFF_CMD, 32'h00000002);
    rd_chk(dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS, {24'h000000, exp_w});
    rd_chk(dcdaw_pkg::OFF_STATUS, {27'h0000000, exp_st});
  endtask

  task automatic no_op_codes();
    wr(dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS, 32'h0000005A);
    wr(dcdaw_pkg::OFF_CMD, 32'h0000A503);
    wr(dcdaw_pkg::OFF_CMD, 32'h0000A500);
    rd_chk(dcdaw_pkg::OFF_WORKING_REGISTER_ALIAS, 32'h0000005A);
  endtask

  // ----------------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    rst_b_in    = 1'b0;
    hsel_in     = 1'b0;
    haddr_in    = 32'h00000000;
    htrans_in   = 2'b00;
    hwrite_in   = 1'b0;
    hsize_in    = 3'b010;
    hwdata_in   = 32'h00000000;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    reset_values();
    dec_case(4'h3, 1'b0, 12'h200, 1'b1, 1'b0, 8'hA5, 12'h3A5, 8'h01, 8'h00, 5'h07);
    dec_case(4'h3, 1'b0, 12'h200, 1'b0, 1'b1, 8'h10, 12'h010, 8'h80, 8'h7F, 5'h09);
    dec_case(4'h3, 1'b0, 12'h200, 1'b0, 1'b1, 8'hE0, 12'hFE0, 8'h00, 8'hFF, 5'h10);
    dec_case(4'h3, 1'b1, 12'h200, 1'b0, 1'b1, 8'h5F, 12'h25F, 8'h10, 8'h0F, 5'h01);
    dec_case(4'h3, 1'b1, 12'h200, 1'b0, 1'b0, 8'h60, 12'hF60, 8'h5A, 8'h59, 5'h03);
    dec_case(4'h7, 1'b1, 12'h200, 1'b1, 1'b1, 8'h20, 12'h720, 8'h42, 8'h41, 5'h03);
    adjust_case(8'hCE, 5'h00, 8'h34, 5'h01);
    adjust_case(8'hA5, 5'h00, 8'h05, 5'h01);
    adjust_case(8'h41, 5'h02, 8'h47, 5'h02);
    adjust_case(8'h99, 5'h01, 8'hF9, 5'h01);
    no_op_codes();
    test_done();
  end

  // Generous bound: the whole sequence needs a few hundred cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    test_done();
  end
endmodule // dcdaw_exec_tb
